// ==== bench/single_wire_bit_coding_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module single_wire_bit_coding_tb;
   logic clk = 1'b0, rst = 1'b1;
   logic m_en = 1'b0, m_bit = 1'b0, s_bit = 1'b0, s_req = 1'b0;
   logic m_take, m_rv, m_rb, m_res, s_rv, s_rb, s_perr, s_take, s_susp;
   int   failures = 0, n_checks = 0, hi = 0, last_hi = 0, k;
   swbc_link_if lnk ();
   swbc_master u_swbc_master (.CLK(clk), .RESET(rst), .LINK(lnk),
      .TX_EN(m_en), .TX_BIT(m_bit), .TX_TAKE(m_take), .RX_VALID(m_rv),
      .RX_BIT(m_rb), .RESUME_SEEN(m_res));
   swbc_slave u_swbc_slave (.CLK(clk), .RESET(rst), .LINK(lnk),
      .EXT_PERIOD(1'b0), .RX_VALID(s_rv), .RX_BIT(s_rb),
      .RX_PERIOD_ERR(s_perr), .TX_BIT(s_bit), .TX_TAKE(s_take),
      .RESUME_REQ(s_req), .SUSPENDED(s_susp));
   swbc_link_assertions u_chk (.CLK(clk), .RESET(rst),
      .master_voltage_signal(lnk.master_voltage_signal),
      .slave_current_signal(lnk.slave_current_signal));
   always #10 clk = ~clk;
   // Own measure of each high phase, kept until the next one ends
   always @(posedge clk) begin
      if (lnk.master_voltage_signal) hi = hi + 1;
      else if (hi != 0) begin
         last_hi = hi;
         hi = 0;
      end
   end
   task summarize;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s exp %b got %b", nm, e, g);
      end
   endtask
   // -------------------------------
   // Scenarios
   // -------------------------------
   task t_resume;
      chk("suspended", 1'b1, s_susp);
      chk("idle current", 1'b0, lnk.slave_current_signal);
      s_req = 1'b1;
      for (k = 0; k < 40 && m_res !== 1'b1; k++) @(negedge clk);
      chk("resume seen", 1'b1, m_res);
      m_en = 1'b1;
      for (k = 0; k < 400 && s_susp !== 1'b0; k++) @(negedge clk);
      chk("slave active", 1'b0, s_susp);
      s_req = 1'b0;
   endtask
   // Slave answers sb throughout; master sends pat msb first
   task t_stream(input logic sb, input logic [15:0] pat);
      int i, n, ns;
      logic tk;
      i = 0; n = 0; ns = 0; tk = 1'b0; s_bit = sb;
      for (k = 0; k < 3000 && i < 16; k++) begin
         @(negedge clk);
         if (tk) i++;
         m_bit = pat[~i[3:0]];
         tk = m_take;
         if (s_rv === 1'b1) begin
            ns++;
            chk("slave bit", last_hi > 50, s_rb);
            chk("period err", 1'b0, s_perr);
         end
         if (m_rv === 1'b1 && ++n > 2) chk("master bit", sb, m_rb);
      end
      chk("bits sent", 1'b1, i == 16);
      chk("bits seen", 1'b1, ns > 13);
   endtask
   task t_suspend;
      int lows;
      lows = 0;
      m_en = 1'b0;
      for (k = 0; k < 300; k++) begin
         @(negedge clk);
         if (k > 150 && lnk.master_voltage_signal !== 1'b1) lows++;
      end
      chk("held high", 1'b1, lows == 0);
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_resume();
      t_stream(1'b1, 16'hA5C3);
      t_stream(1'b0, 16'h3C5A);
      t_suspend();
      summarize();
   end
endmodule
`default_nettype wire

// ==== bench/swbc_link_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module swbc_link_assertions (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Link wire
   input wire logic master_voltage_signal,
   input wire logic slave_current_signal
);
   logic [7:0] hi_r, per_r, hi_nxt, per_nxt;
   logic       v, c, v_r;
   assign v = master_voltage_signal;
   assign c = slave_current_signal;
   // Saturating counts; FF stands for a long suspended high
   assign hi_nxt  = v ? hi_r + {7'h00, hi_r != 8'hFF} : 8'h00;
   assign per_nxt = (v & ~v_r) ? 8'h01 : per_r + {7'h00, per_r != 8'hFF};
   always_ff @(posedge CLK) begin
      hi_r  <= RESET ? 8'hFF : hi_nxt;
      per_r <= RESET ? 8'hFF : per_nxt;
      v_r   <= v;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   // -------------------------------
   // Wire timing at 100 cycle bits
   // -------------------------------
   sequence s_one_fall;  $fell(v) && hi_r == 8'h4B; endsequence
   sequence s_zero_fall; $fell(v) && hi_r == 8'h19; endsequence
   chk_reset_idle: assert property (disable iff (1'b0)
      RESET && $past(RESET) |-> v && !c) else $error("link not idle");
   chk_high_len: assert property ($fell(v) && hi_r < 8'h50
      |-> hi_r == 8'h4B || hi_r == 8'h19) else $error("bad high time");
   chk_one_low: assert property (s_one_fall |-> ##25 $rose(v))
      else $error("one bit low phase wrong");
   chk_zero_low: assert property (s_zero_fall |-> ##75 $rose(v))
      else $error("zero bit low phase wrong");
   chk_period_len: assert property ($rose(v) && per_r < 8'h96
      |-> per_r == 8'h64) else $error("bit period wrong");
   chk_period_range: assert property ($rose(v) && per_r != 8'hFF
      |-> per_r >= 8'h32 && per_r <= 8'hFA) else $error("period range");
   chk_cur_sw_low: assert property ($changed(c) && v && $past(v)
      |-> hi_r >= 8'h50) else $error("current switched while high");
   chk_resume_rise: assert property ($changed(c) && v && $past(v)
      |-> c) else $error("current fell while high");
endmodule
`default_nettype wire

// ==== hdl/swbc_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface swbc_link_if;
   logic master_voltage_signal;
   logic slave_current_signal;
   modport master (output master_voltage_signal, input slave_current_signal);
   modport slave  (input master_voltage_signal, output slave_current_signal);
endinterface
`default_nettype wire

// ==== hdl/swbc_master.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "swbc_regs.svh"
module swbc_master
   import swbc_pkg::*;
(
   // Clock and reset
   input  wire logic CLK,
   input  wire logic RESET,
   // Link
   swbc_link_if.master LINK,
   // Bits to send
   input  wire logic TX_EN,
   input  wire logic TX_BIT,
   output logic      TX_TAKE,
   // Received bits
   output logic      RX_VALID,
   output logic      RX_BIT,
   output logic      RESUME_SEEN
);
   // ---------------------------------------------------------------
   // Pulse-width bit generator
   // ---------------------------------------------------------------
   swbc_mstate_e st_r;
   swbc_cnt_t    cnt_r;
   logic         bit_r;
   logic [2:0]   sync_r;
   logic         cin_r;
   wire  end_bit = cnt_r == (`SWBC_M_PERIOD - 16'h0001);
   wire [15:0] hi_len = bit_r ? `SWBC_M_HIGH1 : `SWBC_M_HIGH0;
   wire  v_high = (st_r == SWBC_M_SUSP) || (cnt_r < hi_len);
   // Sample current near the end of the high phase
   wire  samp = (st_r == SWBC_M_ACT) && (cnt_r == hi_len - 16'h0002);
   assign TX_TAKE = (st_r == SWBC_M_SUSP) ? TX_EN : (end_bit && TX_EN);
   always_ff @(posedge CLK) begin
      if (RESET) begin
         st_r  <= SWBC_M_SUSP;
         cnt_r <= 16'h0000;
         bit_r <= 1'b0;
      end else begin
         unique case (st_r)
            SWBC_M_SUSP: begin
               cnt_r <= 16'h0000;
               if (TX_EN) begin
                  st_r  <= SWBC_M_ACT;
                  bit_r <= TX_BIT;
               end
            end
            SWBC_M_ACT: begin
               if (end_bit) begin
                  cnt_r <= 16'h0000;
                  bit_r <= TX_BIT;
                  if (!TX_EN)
                     st_r <= SWBC_M_SUSP;
               end else
                  cnt_r <= cnt_r + 16'h0001;
            end
            default: st_r <= SWBC_M_SUSP;
         endcase
      end
   end
   logic vout_r;
   always_ff @(posedge CLK) begin
      if (RESET)
         vout_r <= 1'b1;
      else
         vout_r <= v_high;
   end
   assign LINK.master_voltage_signal = vout_r;
   // ---------------------------------------------------------------
   // Current receiver
   // ---------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         sync_r <= 3'h0;
         cin_r  <= 1'b0;
      end else begin
         sync_r <= {sync_r[1:0], LINK.slave_current_signal};
         if (sync_r[2] == sync_r[1])
            cin_r <= sync_r[1];
      end
   end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         RX_VALID    <= 1'b0;
         RX_BIT      <= 1'b0;
         RESUME_SEEN <= 1'b0;
      end else begin
         RX_VALID    <= samp;
         if (samp)
            RX_BIT <= cin_r;
         RESUME_SEEN <= (st_r == SWBC_M_SUSP) && cin_r;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/swbc_pkg.sv ====
package swbc_pkg;
   typedef logic [15:0] swbc_cnt_t;
   typedef enum logic [1:0] {
      SWBC_M_SUSP = 2'b00,
      SWBC_M_ACT  = 2'b01
   } swbc_mstate_e;
endpackage

// ==== hdl/swbc_regs.svh ====
`ifndef SWBC_REGS_SVH
`define SWBC_REGS_SVH
// Bit period limits in ns, default and extended
`define SWBC_T_MIN_NS      1000
`define SWBC_T_MAX_NS      5000
`define SWBC_T_EXT_MIN_NS  590
`define SWBC_T_EXT_MAX_NS  10000
`define SWBC_CLK_NS        20
// Period counts: least rounds up, longest rounds down
`define SWBC_T_MIN_CYC     ((`SWBC_T_MIN_NS + `SWBC_CLK_NS - 1) / `SWBC_CLK_NS)
`define SWBC_T_MAX_CYC     (`SWBC_T_MAX_NS / `SWBC_CLK_NS)
`define SWBC_T_EXT_MIN_CYC ((`SWBC_T_EXT_MIN_NS + `SWBC_CLK_NS - 1) / `SWBC_CLK_NS)
`define SWBC_T_EXT_MAX_CYC (`SWBC_T_EXT_MAX_NS / `SWBC_CLK_NS)
// Master divider: period in cycles for nominal bit, high time quarters
`define SWBC_M_PERIOD      16'h0064
`define SWBC_M_HIGH1       16'h004B
`define SWBC_M_HIGH0       16'h0019
`define SWBC_CNT_W         16
`endif

// ==== hdl/swbc_slave.sv ====
// Function
// - Master one: high 70 to 80 percent
// - Master zero: high 20 to 30 percent
// - Master sends bits back to back
// - Bit boundaries only from rising edges
// - Decode each bit against own period
// - Period 1-5 us, extended 0.59-10 us
// - Master samples current only while high
// - Slave switches current only while low, except to resume
// - Suspended: voltage high, current low
// - Slave resumes by raising current while high
`timescale 1ns/1ps
`default_nettype none
`include "swbc_regs.svh"
module swbc_slave
   import swbc_pkg::*;
(
   // Clock and reset
   input  wire logic CLK,
   input  wire logic RESET,
   // Link
   swbc_link_if.slave LINK,
   // Mode
   input  wire logic EXT_PERIOD,
   // Received bits
   output logic      RX_VALID,
   output logic      RX_BIT,
   output logic      RX_PERIOD_ERR,
   // Bits to send
   input  wire logic TX_BIT,
   output logic      TX_TAKE,
   input  wire logic RESUME_REQ,
   output logic      SUSPENDED
);
   // ---------------------------------------------------------------
   // Input synchroniser
   // ---------------------------------------------------------------
   logic [2:0] sync_r;
   logic       vin_r;
   always_ff @(posedge CLK) begin
      if (RESET) begin
         sync_r <= 3'h7;
         vin_r  <= 1'b1;
      end else begin
         sync_r <= {sync_r[1:0], LINK.master_voltage_signal};
         if (sync_r[2] == sync_r[1])
            vin_r <= sync_r[1];
      end
   end
   logic vin_d_r;
   always_ff @(posedge CLK) begin
      if (RESET)
         vin_d_r <= 1'b1;
      else
         vin_d_r <= vin_r;
   end
   wire rise = vin_r & ~vin_d_r;
   wire fall = ~vin_r & vin_d_r;
   // ---------------------------------------------------------------
   // Period and high-time measurement
   // ---------------------------------------------------------------
   swbc_cnt_t per_r;
   swbc_cnt_t high_r;
   logic      in_bit_r;
   wire [15:0] per_lo = EXT_PERIOD ? 16'(`SWBC_T_EXT_MIN_CYC)
                                   : 16'(`SWBC_T_MIN_CYC);
   wire [15:0] per_hi = EXT_PERIOD ? 16'(`SWBC_T_EXT_MAX_CYC)
                                   : 16'(`SWBC_T_MAX_CYC);
   // Period spans the just-closed bit, measured rising to rising
   wire        per_ok = (per_r >= per_lo) && (per_r <= per_hi);
   // Sub-cycle period resolution: ties decode as zero
   wire        dec_one = {high_r, 1'b0} > {1'b0, per_r};
   // Silence longer than any period means suspended link
   wire        idle_to = per_r == 16'hFFFF;
   always_ff @(posedge CLK) begin
      if (RESET) begin
         per_r    <= 16'h0000;
         high_r   <= 16'h0000;
         in_bit_r <= 1'b0;
      end else if (rise) begin
         per_r    <= 16'h0001;
         high_r   <= 16'h0001;
         in_bit_r <= 1'b1;
      end else begin
         if (!idle_to)
            per_r <= per_r + 16'h0001;
         if (vin_r && !idle_to)
            high_r <= high_r + 16'h0001;
         if (idle_to)
            in_bit_r <= 1'b0;
      end
   end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         RX_VALID      <= 1'b0;
         RX_BIT        <= 1'b0;
         RX_PERIOD_ERR <= 1'b0;
      end else begin
         RX_VALID      <= rise && in_bit_r && !idle_to;
         RX_PERIOD_ERR <= rise && in_bit_r && !idle_to && !per_ok;
         if (rise && in_bit_r)
            RX_BIT <= dec_one;
      end
   end
   // ---------------------------------------------------------------
   // Current output
   // ---------------------------------------------------------------
   logic cur_r;
   logic susp_r;
   logic woke_r;
   always_ff @(posedge CLK) begin
      if (RESET)
         susp_r <= 1'b1;
      else if (rise && in_bit_r && !idle_to)
         susp_r <= 1'b0;
      else if (idle_to && vin_r)
         susp_r <= 1'b1;
   end
   assign SUSPENDED = susp_r;
   // Set by the first low phase after suspend; the resume window is closed
   always_ff @(posedge CLK) begin
      if (RESET)
         woke_r <= 1'b0;
      else if (fall)
         woke_r <= 1'b1;
      else if (idle_to && vin_r)
         woke_r <= 1'b0;
   end
   // Next bit is loaded on the falling edge so it holds over the high
   assign TX_TAKE = fall && !susp_r;
   always_ff @(posedge CLK) begin
      if (RESET)
         cur_r <= 1'b0;
      else if (fall)
         cur_r <= susp_r ? 1'b0 : TX_BIT;
      // Only the suspended high may see a switch while the voltage is high
      else if (susp_r && !woke_r)
         cur_r <= RESUME_REQ && vin_r;
   end
   assign LINK.slave_current_signal = cur_r;
endmodule
`default_nettype wire
